// File: rtl/vvlp_pkg.sv
// Purpose: constants shared by the video vector and look-up processor
// Assumes: 50 MHz system clock, byte-wide host I/O registers
// Notes:   register offsets are relative to a 16-byte aligned base
package vvlp_pkg;
  // register offsets
  localparam logic [3:0] OFS_LUT_ADDR_LOW   = 4'h0;
  localparam logic [3:0] OFS_LUT_ADDR_HIGH  = 4'h1;
  localparam logic [3:0] OFS_GAIN_OFFSET    = 4'h2;
  localparam logic [3:0] OFS_MODE           = 4'h3;
  localparam logic [3:0] OFS_SLOPE_LOW      = 4'h4;
  localparam logic [3:0] OFS_LENGTH_LOW     = 4'h5;
  localparam logic [3:0] OFS_PATTERN        = 4'h6;
  localparam logic [3:0] OFS_LAUNCH         = 4'h7;
  localparam logic [3:0] OFS_RED_PORT       = 4'h8;
  localparam logic [3:0] OFS_BLUE_PORT      = 4'h9;
  localparam logic [3:0] OFS_GREEN_PORT     = 4'hA;
  localparam logic [3:0] OFS_STATUS         = 4'hB;
  // launch register fields
  localparam int LCH_SLOPE_HI   = 0;
  localparam int LCH_COMPLEMENT = 2;
  localparam int LCH_BELOW_45   = 3;
  localparam int LCH_QUADRANT   = 4;
  localparam int LCH_LENGTH_HI  = 6;
  // mode register fields
  localparam int MODE_INPUT_SEL = 0;
  localparam int MODE_SYNC_GEN  = 2;
  localparam int MODE_BLOCK     = 3;
  localparam int MODE_OVERLAY   = 4;
  localparam int MODE_RATE_FAST = 5;
  localparam int MODE_BLINK     = 6;
  localparam int MODE_OVL_ONLY  = 7;
  // gain/offset fields, status busy bit and register reset value
  localparam int GO_OFFSET      = 0;
  localparam int GO_GAIN        = 4;
  localparam int STATUS_BUSY    = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int PIXEL_TIME_NS  = 800;
  localparam int PIXEL_CYCLES   = (PIXEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint CLK_HZ         = 64'd50000000;
  localparam longint BLINK_SLOW_MHZ = 64'd1800;
  localparam longint BLINK_FAST_MHZ = 64'd3750;
  localparam int BLINK_SLOW_HALF = int'((CLK_HZ * 64'd1000) / (64'd2 * BLINK_SLOW_MHZ));
  localparam int BLINK_FAST_HALF = int'((CLK_HZ * 64'd1000) / (64'd2 * BLINK_FAST_MHZ));
  // look-up sections
  localparam logic [1:0] SEC_NORMAL      = 2'h0;
  localparam logic [1:0] SEC_OVERLAY     = 2'h1;
  localparam logic [1:0] SEC_BLINK       = 2'h2;
  localparam logic [1:0] SEC_BLINK_OVL   = 2'h3;
endpackage : vvlp_pkg

// File: rtl/vvlp_vec_if.sv
// Purpose: carrier between register block and vector generator
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/100ps
interface vvlp_vec_if;
  logic       start;
  logic [9:0] slope;
  logic [9:0] length;
  logic [7:0] pattern;
  logic       complement;
  logic       below_45;
  logic [1:0] quadrant;
  logic       busy;
  logic       x_step;
  logic       y_step;
  logic       x_neg;
  logic       y_neg;
  logic       draw;
  modport ctl (output start, slope, length, pattern, complement, below_45, quadrant,
               input busy, x_step, y_step, x_neg, y_neg, draw);
  modport gen (input start, slope, length, pattern, complement, below_45, quadrant,
               output busy, x_step, y_step, x_neg, y_neg, draw);
endinterface : vvlp_vec_if

// File: rtl/vvlp_vecgen.sv
// Purpose: incremental line generator issuing X/Y step strobes
// Assumes: parameters stable from launch to completion
// Notes:   a launch while busy is ignored
`timescale 1ns/100ps
module vvlp_vecgen
  import vvlp_pkg::*;
#(
  parameter int PACE = vvlp_pkg::PIXEL_CYCLES
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  vvlp_vec_if.gen         vec
);
  typedef enum logic {VVLP_IDLE, VVLP_DRAW} vvlp_state_e;
  vvlp_state_e state_q;
  logic [5:0]  pace_q;
  logic [10:0] remain_q;
  logic [9:0]  acc_q;
  logic [2:0]  bit_q;
  logic [10:0] sum;
  logic        tick;

  assign sum  = {1'b0, acc_q} + {1'b0, vec.slope};
  assign tick = (state_q == VVLP_DRAW) && (pace_q == 6'(PACE - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q  <= VVLP_IDLE;
      vec.busy <= 1'b0;
    end else begin
      unique case (state_q)
        VVLP_IDLE: if (vec.start) begin
          state_q  <= VVLP_DRAW;
          vec.busy <= 1'b1;
        end
        VVLP_DRAW: if (tick && remain_q == 11'h001) begin
          state_q  <= VVLP_IDLE;
          vec.busy <= 1'b0;
        end
      endcase
    end
  end

  // one pixel per pace period
  always_ff @(posedge i_clock) begin
    if (i_rst || state_q == VVLP_IDLE || tick) begin
      pace_q <= 6'h00;
    end else begin
      pace_q <= pace_q + 6'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      remain_q <= 11'h000;
      acc_q    <= 10'h000;
      bit_q    <= 3'h0;
    end else if (state_q == VVLP_IDLE && vec.start) begin
      // zero length stands for the full 1024 pixels
      remain_q <= (vec.length == 10'h000) ? 11'h400 : {1'b0, vec.length};
      acc_q    <= 10'h000;
      bit_q    <= 3'h0;
    end else if (tick) begin
      remain_q <= remain_q - 11'h001;
      acc_q    <= sum[9:0];
      bit_q    <= bit_q + 3'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      vec.x_step <= 1'b0;
      vec.y_step <= 1'b0;
      vec.x_neg  <= 1'b0;
      vec.y_neg  <= 1'b0;
      vec.draw   <= 1'b0;
    end else begin
      // major axis steps every pixel, minor axis on accumulator carry
      vec.x_step <= tick && (vec.below_45 || sum[10]);
      vec.y_step <= tick && (!vec.below_45 || sum[10]);
      vec.x_neg  <= vec.quadrant[0];
      vec.y_neg  <= vec.quadrant[1];
      vec.draw   <= tick && (vec.pattern[bit_q] ^ vec.complement);
    end
  end
endmodule : vvlp_vecgen

// File: rtl/vvlp_top.sv
// Purpose: video processor with vector generator, grabber control and colour look-up
// Assumes: host I/O strobes are synchronous to i_clock; video bus pins are not
// Notes:   look-up memories have no reset; software loads them before display
`timescale 1ns/100ps
module vvlp_top
  import vvlp_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR       = 16'h0060,
  parameter bit          DUAL_GRAPHICS   = 1'b1,
  parameter int          GRAB_BITS       = 8,
  parameter int          BLINK_SLOW_CYC  = vvlp_pkg::BLINK_SLOW_HALF,
  parameter int          BLINK_FAST_CYC  = vvlp_pkg::BLINK_FAST_HALF
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // host I/O bus
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  output logic             o_io_ack,
  // video bus from graphics and alphanumeric boards
  input  wire logic [7:0]  i_gfx_bits,
  input  wire logic [3:0]  i_alpha_bits,
  input  wire logic        i_grab_live,
  input  wire logic        i_grab_once,
  input  wire logic        i_frame_start,
  input  wire logic [7:0]  i_adc_data,
  // look-up outputs
  output logic      [7:0]  o_red,
  output logic      [7:0]  o_green,
  output logic      [7:0]  o_blue,
  // vector strobes
  output logic             o_x_step,
  output logic             o_y_step,
  output logic             o_x_neg,
  output logic             o_y_neg,
  output logic             o_draw,
  // grabber and analog front-end controls
  output logic      [7:0]  o_grab_data,
  output logic             o_grab_valid,
  output logic      [1:0]  o_video_input_sel,
  output logic             o_sync_gen_en,
  output logic             o_block_sync,
  output logic      [3:0]  o_gain_sel,
  output logic      [3:0]  o_offset_sel
);
  localparam int BLINK_W = 25;

  vvlp_vec_if vec ();

  logic [7:0]  lut_addr_low_q;
  logic [1:0]  lut_addr_high_q;
  logic [7:0]  gain_offset_q;
  logic [7:0]  mode_q;
  logic [7:0]  slope_low_q;
  logic [7:0]  length_low_q;
  logic [7:0]  pattern_q;
  logic [7:0]  launch_q;
  logic        launch_q_pulse;
  logic [7:0]  red_mem   [1024];
  logic [7:0]  green_mem [1024];
  logic [7:0]  blue_mem  [1024];
  logic [9:0]  host_idx;
  logic        wr_hit;
  logic        rd_hit;
  logic [3:0]  ofs;
  logic [7:0]  rd_d;

  logic [7:0]  gfx_s1_q;
  logic [7:0]  gfx_s2_q;
  logic [3:0]  alpha_s1_q;
  logic [3:0]  alpha_s2_q;
  logic [7:0]  adc_s1_q;
  logic [7:0]  adc_s2_q;
  logic [2:0]  ctl_s1_q;
  logic [2:0]  ctl_s2_q;
  logic        frame_prev_q;
  logic        frame_edge;

  logic [BLINK_W-1:0] blink_cnt_q;
  logic        blink_phase_q;
  logic [BLINK_W-1:0] blink_half;

  logic [7:0]  pix_index;
  logic        overlay_hit;
  logic        blink_now;
  logic [1:0]  section;
  logic [9:0]  pix_addr;

  logic        once_armed_q;
  logic        grab_frame_q;

  // decode of a host strobe against the 16-byte aligned window
  function automatic logic in_window(input logic [15:0] addr);
    in_window = (addr[15:4] == BASE_ADDR[15:4]) && (addr[3:0] <= OFS_STATUS);
  endfunction

  assign ofs      = i_io_addr[3:0];
  assign wr_hit   = i_io_wr && in_window(i_io_addr);
  assign rd_hit   = i_io_rd && in_window(i_io_addr);
  assign host_idx = {lut_addr_high_q, lut_addr_low_q};

  // control registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lut_addr_low_q  <= REG_RESET;
      lut_addr_high_q <= 2'h0;
      gain_offset_q   <= REG_RESET;
      mode_q          <= REG_RESET;
      slope_low_q     <= REG_RESET;
      length_low_q    <= REG_RESET;
      pattern_q       <= REG_RESET;
      launch_q        <= REG_RESET;
    end else if (wr_hit) begin
      unique case (ofs)
        OFS_LUT_ADDR_LOW:  lut_addr_low_q  <= i_io_wdata;
        OFS_LUT_ADDR_HIGH: lut_addr_high_q <= i_io_wdata[1:0];
        OFS_GAIN_OFFSET:   gain_offset_q   <= i_io_wdata;
        OFS_MODE:          mode_q          <= i_io_wdata;
        OFS_SLOPE_LOW:     slope_low_q     <= i_io_wdata;
        OFS_LENGTH_LOW:    length_low_q    <= i_io_wdata;
        OFS_PATTERN:       pattern_q       <= i_io_wdata;
        // the launch register is frozen while a line is in progress; slope, length and pattern registers are not
        OFS_LAUNCH:        if (!vec.busy) launch_q <= i_io_wdata;
        default:           ;
      endcase
    end
  end

  // launch pulse one cycle after the write, once the fields are stored
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      launch_q_pulse <= 1'b0;
    end else begin
      launch_q_pulse <= wr_hit && (ofs == OFS_LAUNCH) && !vec.busy;
    end
  end

  assign vec.start      = launch_q_pulse;
  assign vec.slope      = {launch_q[LCH_SLOPE_HI +: 2], slope_low_q};
  assign vec.length     = {launch_q[LCH_LENGTH_HI +: 2], length_low_q};
  assign vec.pattern    = pattern_q;
  assign vec.complement = launch_q[LCH_COMPLEMENT];
  assign vec.below_45   = launch_q[LCH_BELOW_45];
  assign vec.quadrant   = launch_q[LCH_QUADRANT +: 2];

  vvlp_vecgen #(
    .PACE (PIXEL_CYCLES)
  ) u_vecgen (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .vec     (vec)
  );

  // host side of the look-up memories
  always_ff @(posedge i_clock) begin
    if (wr_hit && ofs == OFS_RED_PORT) begin
      red_mem[host_idx] <= i_io_wdata;
    end
    if (wr_hit && ofs == OFS_GREEN_PORT) begin
      green_mem[host_idx] <= i_io_wdata;
    end
    if (wr_hit && ofs == OFS_BLUE_PORT) begin
      blue_mem[host_idx] <= i_io_wdata;
    end
  end

  always_comb begin
    rd_d = 8'h00;
    unique case (ofs)
      OFS_LUT_ADDR_LOW:  rd_d = lut_addr_low_q;
      OFS_LUT_ADDR_HIGH: rd_d = {6'h00, lut_addr_high_q};
      OFS_GAIN_OFFSET:   rd_d = gain_offset_q;
      OFS_MODE:          rd_d = mode_q;
      OFS_SLOPE_LOW:     rd_d = slope_low_q;
      OFS_LENGTH_LOW:    rd_d = length_low_q;
      OFS_PATTERN:       rd_d = pattern_q;
      OFS_LAUNCH:        rd_d = launch_q;
      OFS_RED_PORT:      rd_d = red_mem[host_idx];
      OFS_BLUE_PORT:     rd_d = blue_mem[host_idx];
      OFS_GREEN_PORT:    rd_d = green_mem[host_idx];
      OFS_STATUS:        rd_d = {7'h00, vec.busy};
      default:           rd_d = 8'h00;
    endcase
  end

  // every access inside the window is acknowledged one cycle later
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_io_rdata <= 8'h00;
      o_io_ack   <= 1'b0;
    end else begin
      o_io_rdata <= rd_hit ? rd_d : 8'h00;
      o_io_ack   <= rd_hit || wr_hit;
    end
  end

  // video bus pins come from other boards: two stages before use
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gfx_s1_q   <= 8'h00;
      gfx_s2_q   <= 8'h00;
      alpha_s1_q <= 4'h0;
      alpha_s2_q <= 4'h0;
      adc_s1_q   <= 8'h00;
      adc_s2_q   <= 8'h00;
      ctl_s1_q   <= 3'h0;
      ctl_s2_q   <= 3'h0;
    end else begin
      gfx_s1_q   <= i_gfx_bits;
      gfx_s2_q   <= gfx_s1_q;
      alpha_s1_q <= i_alpha_bits;
      alpha_s2_q <= alpha_s1_q;
      adc_s1_q   <= i_adc_data;
      adc_s2_q   <= adc_s1_q;
      ctl_s1_q   <= {i_frame_start, i_grab_once, i_grab_live};
      ctl_s2_q   <= ctl_s1_q;
    end
  end

  // blink phase generator; the half period follows the selected rate
  assign blink_half = mode_q[MODE_RATE_FAST] ? BLINK_W'(BLINK_FAST_CYC) : BLINK_W'(BLINK_SLOW_CYC);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      blink_cnt_q   <= '0;
      blink_phase_q <= 1'b0;
    end else if (blink_cnt_q >= blink_half - BLINK_W'(1)) begin
      blink_cnt_q   <= '0;
      blink_phase_q <= !blink_phase_q;
    end else begin
      blink_cnt_q   <= blink_cnt_q + BLINK_W'(1);
    end
  end

  // pixel look-up path
  always_comb begin
    pix_index = DUAL_GRAPHICS ? gfx_s2_q : {4'h0, gfx_s2_q[3:0]};
    overlay_hit = 1'b0;
    if (mode_q[MODE_OVERLAY]) begin
      // alphanumeric bits take the upper graphics nibble
      pix_index[7:4] = alpha_s2_q;
      overlay_hit    = |alpha_s2_q;
    end
    blink_now = mode_q[MODE_BLINK] && blink_phase_q &&
                (!mode_q[MODE_OVL_ONLY] || overlay_hit);
    unique case ({blink_now, overlay_hit})
      2'b00:   section = SEC_NORMAL;
      2'b01:   section = SEC_OVERLAY;
      2'b10:   section = SEC_BLINK;
      default: section = SEC_BLINK_OVL;
    endcase
    pix_addr = {section, pix_index};
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_red   <= 8'h00;
      o_green <= 8'h00;
      o_blue  <= 8'h00;
    end else begin
      o_red   <= red_mem[pix_addr];
      o_green <= green_mem[pix_addr];
      o_blue  <= blue_mem[pix_addr];
    end
  end

  // frame grabber: live grabs every frame, single shot grabs the next whole frame
  assign frame_edge = ctl_s2_q[2] && !frame_prev_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      frame_prev_q <= 1'b0;
      once_armed_q <= 1'b0;
      grab_frame_q <= 1'b0;
    end else begin
      frame_prev_q <= ctl_s2_q[2];
      if (frame_edge) begin
        grab_frame_q <= ctl_s2_q[0] || once_armed_q || ctl_s2_q[1];
        once_armed_q <= 1'b0;
      end else if (ctl_s2_q[1]) begin
        // request seen mid-frame waits for the next frame start
        once_armed_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_grab_data  <= 8'h00;
      o_grab_valid <= 1'b0;
    end else begin
      // low resolution keeps the upper bits of the converter
      o_grab_data  <= (GRAB_BITS == 4) ? {adc_s2_q[7:4], 4'h0} : adc_s2_q;
      o_grab_valid <= grab_frame_q;
    end
  end

  // analog front-end controls, registered copies of the mode and gain/offset fields
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_video_input_sel <= 2'h0;
      o_sync_gen_en     <= 1'b0;
      o_block_sync      <= 1'b0;
      o_gain_sel        <= 4'h0;
      o_offset_sel      <= 4'h0;
    end else begin
      o_video_input_sel <= mode_q[MODE_INPUT_SEL +: 2];
      o_sync_gen_en     <= mode_q[MODE_SYNC_GEN];
      o_block_sync      <= mode_q[MODE_BLOCK];
      o_gain_sel        <= gain_offset_q[GO_GAIN +: 4];
      o_offset_sel      <= gain_offset_q[GO_OFFSET +: 4];
    end
  end

  assign o_x_step = vec.x_step;
  assign o_y_step = vec.y_step;
  assign o_x_neg  = vec.x_neg;
  assign o_y_neg  = vec.y_neg;
  assign o_draw   = vec.draw;
endmodule : vvlp_top

// File: tb/vvlp_top_properties.sv
// Purpose: port-level checks for the video processor
// Assumes: host strobes synchronous to i_clock, one access per cycle
// Notes:   pace window allows the shortest gap between two lines
`timescale 1ns/100ps
module vvlp_chk
  import vvlp_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = 16'h0060
) (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [15:0] i_io_addr,
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic [7:0]  i_io_wdata,
  input wire logic [7:0]  o_io_rdata,
  input wire logic        o_io_ack,
  input wire logic        o_x_step,
  input wire logic        o_y_step,
  input wire logic        o_x_neg,
  input wire logic        o_y_neg,
  input wire logic        o_draw,
  input wire logic [1:0]  o_video_input_sel,
  input wire logic        o_sync_gen_en,
  input wire logic        o_block_sync,
  input wire logic [3:0]  o_gain_sel,
  input wire logic [3:0]  o_offset_sel
);
  logic       step;
  logic       hit;
  logic       wr_mode;
  logic       wr_gain;
  logic [3:0] mode_now;
  logic [5:0] gap_q;
  logic [5:0] gap_d;
  assign step = o_x_step | o_y_step;
  assign hit = (i_io_wr | i_io_rd) && i_io_addr[15:4] == BASE_ADDR[15:4] && i_io_addr[3:0] <= OFS_STATUS;
  assign wr_mode = i_io_wr && i_io_addr == (BASE_ADDR | 16'h0003);
  assign wr_gain = i_io_wr && i_io_addr == (BASE_ADDR | 16'h0002);
  assign mode_now = {o_block_sync, o_sync_gen_en, o_video_input_sel};
  // saturates at 41: the earliest a new line can step after the previous one ended
  assign gap_d = step ? 6'h00 : (gap_q == 6'd41 ? gap_q : gap_q + 6'h01);
  always_ff @(posedge i_clock) begin
    if (i_rst) gap_q <= 6'd41;
    else gap_q <= gap_d;
  end
  chk_ack_window: assert property (@(posedge i_clock) disable iff (i_rst) hit |=> o_io_ack)
    else $error("no ack after a register access");
  chk_ack_refused: assert property (@(posedge i_clock) disable iff (i_rst) (i_io_wr | i_io_rd) && !hit |=> !o_io_ack)
    else $error("ack after an unmapped access");
  chk_rdata_idle: assert property (@(posedge i_clock) disable iff (i_rst) !o_io_ack |-> o_io_rdata == 8'h00)
    else $error("read data outside an ack");
  chk_pixel_pace: assert property (@(posedge i_clock) disable iff (i_rst) step |-> gap_q == 6'd39 || gap_q == 6'd41)
    else $error("pixel step spacing wrong");
  chk_draw_on_step: assert property (@(posedge i_clock) disable iff (i_rst) o_draw |-> step)
    else $error("draw without a step");
  chk_dir_steady: assert property (@(posedge i_clock) disable iff (i_rst) step |-> $stable(o_x_neg) && $stable(o_y_neg))
    else $error("direction changed at a step");
  chk_mode_out: assert property (@(posedge i_clock) disable iff (i_rst) wr_mode |-> ##2 mode_now == $past(i_io_wdata[3:0], 2))
    else $error("mode outputs do not follow write");
  chk_gain_out: assert property (@(posedge i_clock) disable iff (i_rst) wr_gain |-> ##2 {o_gain_sel, o_offset_sel} == $past(i_io_wdata, 2))
    else $error("gain outputs do not follow write");
endmodule // vvlp_chk
bind vvlp_top vvlp_chk #(.BASE_ADDR(BASE_ADDR)) i_vvlp_chk (.*);

// File: tb/vvlp_board_model.sv
// Purpose: graphics and overlay boards on the video bus
// Assumes: strobes are one-cycle pulses in the i_clock domain
// Notes:   pins change just after an edge so sync stages see clean levels
`timescale 1ns/100ps
module vvlp_board_model (
  input wire logic  i_clock,
  input wire logic  i_x_step,
  input wire logic  i_y_step,
  input wire logic  i_x_neg,
  input wire logic  i_y_neg,
  input wire logic  i_draw,
  output logic [7:0] o_gfx_bits,
  output logic [3:0] o_alpha_bits,
  output logic [7:0] o_adc_data,
  output logic       o_frame_start
);
  int xs = 0;
  int ys = 0;
  int ds = 0;
  int xp = 0;
  int yp = 0;
  initial {o_gfx_bits, o_alpha_bits, o_adc_data, o_frame_start} = '0;
  task automatic clear();
    {xs, ys, ds, xp, yp} = '0;
  endtask
  task automatic show(input logic [7:0] g, input logic [3:0] a, input logic [7:0] d, input logic f);
    @(posedge i_clock);
    #1 {o_gfx_bits, o_alpha_bits, o_adc_data, o_frame_start} = {g, a, d, f};
  endtask
  always @(posedge i_clock) begin
    if (i_x_step === 1'b1) begin xs++; xp += i_x_neg ? -1 : 1; end
    if (i_y_step === 1'b1) begin ys++; yp += i_y_neg ? -1 : 1; end
    if (i_draw === 1'b1) ds++;
  end
endmodule // vvlp_board_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the video processor
// Assumes: short blink counts, default base and dual graphics boards
// Notes:   every access leaves one idle cycle so a strobe is never re-driven at once
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import vvlp_pkg::*;
  localparam logic [15:0] BASE = 16'h0060;
  logic i_clock = 0, i_rst = 1, i_io_wr = 0, i_io_rd = 0, i_grab_live = 0, i_grab_once = 0;
  logic [15:0] i_io_addr = '0;
  logic [7:0] i_io_wdata = '0, o_io_rdata, o_red, o_green, o_blue, o_grab_data, gfx, adc;
  logic [3:0] alpha, o_gain_sel, o_offset_sel;
  logic [1:0] o_video_input_sel;
  logic o_io_ack, o_x_step, o_y_step, o_x_neg, o_y_neg, o_draw, o_grab_valid, o_sync_gen_en, o_block_sync, fs;
  int err_count = 0, comparisons = 0, cyc = 0;
  vvlp_top #(.BASE_ADDR(BASE), .BLINK_SLOW_CYC(8), .BLINK_FAST_CYC(4)) i_vvlp_top (.i_clock(i_clock),
    .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
    .o_io_rdata(o_io_rdata), .o_io_ack(o_io_ack), .i_gfx_bits(gfx), .i_alpha_bits(alpha),
    .i_grab_live(i_grab_live), .i_grab_once(i_grab_once), .i_frame_start(fs), .i_adc_data(adc),
    .o_red(o_red), .o_green(o_green), .o_blue(o_blue), .o_x_step(o_x_step), .o_y_step(o_y_step),
    .o_x_neg(o_x_neg), .o_y_neg(o_y_neg), .o_draw(o_draw), .o_grab_data(o_grab_data),
    .o_grab_valid(o_grab_valid), .o_video_input_sel(o_video_input_sel), .o_sync_gen_en(o_sync_gen_en),
    .o_block_sync(o_block_sync), .o_gain_sel(o_gain_sel), .o_offset_sel(o_offset_sel));
  vvlp_board_model i_vvlp_board_model (.i_clock(i_clock), .i_x_step(o_x_step), .i_y_step(o_y_step),
    .i_x_neg(o_x_neg), .i_y_neg(o_y_neg), .i_draw(o_draw), .o_gfx_bits(gfx), .o_alpha_bits(alpha),
    .o_adc_data(adc), .o_frame_start(fs));
  always #10 i_clock = ~i_clock;
  // the 1024-pixel line alone needs about 41k cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 95000) begin err_count++; complete_run(); end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) begin @(posedge i_clock); #1; end
  endtask
  task automatic io(input bit w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q, output logic k);
    step(1);
    {i_io_wr, i_io_rd, i_io_addr, i_io_wdata} = {w, !w, a, d};
    step(1);
    {i_io_wr, i_io_rd} = 2'b00;
    {q, k} = {o_io_rdata, o_io_ack};
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    io(1, BASE | 16'(o), d, q, k);
    `CHK(k, 1'b1)
  endtask
  task automatic rd(input logic [3:0] o, output logic [7:0] q);
    logic k;
    io(0, BASE | 16'(o), 8'h00, q, k);
    `CHK(k, 1'b1)
  endtask
  task automatic t_regs();
    logic [7:0] q;
    logic k;
    for (int i = 0; i < 7; i++) wr(4'(i), 8'h5A ^ 8'(i));
    // the address-high register keeps only its two table-address bits
    for (int i = 0; i < 7; i++) begin rd(4'(i), q); `CHK(q, (i == 1) ? 8'h03 : 8'h5A ^ 8'(i)) end
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, q);
    `CHK(q[STATUS_BUSY], 1'b0)
    io(0, BASE | 16'h000C, 8'h00, q, k);
    `CHK(k, 1'b0)
    io(1, BASE ^ 16'h0107, 8'h00, q, k);
    `CHK(k, 1'b0)
    for (int i = 0; i < 4; i++) begin wr(OFS_MODE, 8'(i)); step(2); `CHK(o_video_input_sel, 2'(i)) end
    $display("test regs done");
  endtask
  task automatic blink(output int n, output logic [7:0] x);
    logic [7:0] a;
    {a, n} = {o_red, 32'd0};
    repeat (40) begin step(1); if (o_red !== a) break; end
    a = o_red;
    repeat (40) begin step(1); n++; if (o_red !== a) break; end
    x = a ^ o_red;
  endtask
  task automatic t_lut();
    logic [7:0] q;
    logic [7:0] x;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_LUT_ADDR_HIGH, 8'(s));
      wr(OFS_LUT_ADDR_LOW, 8'hC5);
      wr(OFS_RED_PORT, 8'h10 + 8'(s));
      wr(OFS_BLUE_PORT, 8'h30 + 8'(s));
      wr(OFS_GREEN_PORT, 8'h20 + 8'(s));
    end
    for (int s = 0; s < 4; s++) begin
      wr(OFS_LUT_ADDR_HIGH, 8'(s));
      wr(OFS_LUT_ADDR_LOW, 8'hC5);
      rd(OFS_RED_PORT, q); `CHK(q, 8'h10 + 8'(s))
      rd(OFS_BLUE_PORT, q); `CHK(q, 8'h30 + 8'(s))
      rd(OFS_GREEN_PORT, q); `CHK(q, 8'h20 + 8'(s))
    end
    wr(OFS_MODE, 8'h00);
    i_vvlp_board_model.show(8'hC5, 4'h0, 8'h00, 1'b0);
    step(5);
    `CHK({o_red, o_green, o_blue}, 24'h102030)
    wr(OFS_MODE, 8'h10);
    i_vvlp_board_model.show(8'h05, 4'hC, 8'h00, 1'b0);
    step(5);
    `CHK(o_red, 8'h11)
    wr(OFS_MODE, 8'hD0);
    blink(n, x);
    `CHK({n[7:0], x}, 16'h0802)
    wr(OFS_MODE, 8'h40);
    i_vvlp_board_model.show(8'hC5, 4'h0, 8'h00, 1'b0);
    // let the new pixel reach the output so only blink toggles are timed
    step(5);
    blink(n, x);
    `CHK({n[7:0], x}, 16'h0802)
    wr(OFS_MODE, 8'h60);
    blink(n, x);
    `CHK({n[7:0], x}, 16'h0402)
    $display("test table done");
  endtask
  task automatic vec(input logic [9:0] sl, input logic [9:0] ln, input logic [7:0] pat, input logic [3:0] c,
                     input int ex, input int ey, input int ed, input bit again);
    logic [7:0] q;
    int n;
    wr(OFS_SLOPE_LOW, sl[7:0]);
    wr(OFS_LENGTH_LOW, ln[7:0]);
    wr(OFS_PATTERN, pat);
    i_vvlp_board_model.clear();
    wr(OFS_LAUNCH, {ln[9:8], c, sl[9:8]});
    n = 0;
    repeat (60) begin step(1); n++; if ((o_x_step | o_y_step) === 1'b1) break; end
    `CHK(n, 41)
    rd(OFS_STATUS, q);
    `CHK(q[STATUS_BUSY], 1'b1)
    // a second launch mid-line with another direction must leave the line untouched
    if (again) wr(OFS_LAUNCH, 8'h08);
    repeat (30000) begin rd(OFS_STATUS, q); if (q[STATUS_BUSY] === 1'b0) break; end
    `CHK(q[STATUS_BUSY], 1'b0)
    `CHK(i_vvlp_board_model.xs, ex)
    `CHK(i_vvlp_board_model.ys, ey)
    `CHK(i_vvlp_board_model.ds, ed)
    `CHK(i_vvlp_board_model.xp, c[2] ? -ex : ex)
    `CHK(i_vvlp_board_model.yp, c[3] ? -ey : ey)
  endtask
  task automatic t_vec();
    vec(10'h200, 10'd8, 8'h07, 4'b0110, 8, 4, 3, 1);
    vec(10'h000, 10'd10, 8'h01, 4'b1001, 0, 10, 8, 0);
    vec(10'h000, 10'd0, 8'hFF, 4'b0010, 1024, 0, 1024, 0);
    $display("test vector done");
  endtask
  task automatic t_grab();
    i_grab_live = 1'b1;
    i_vvlp_board_model.show(8'h00, 4'h0, 8'h5A, 1'b1);
    step(3);
    i_vvlp_board_model.show(8'h00, 4'h0, 8'h5A, 1'b0);
    step(8);
    `CHK({o_grab_valid, o_grab_data}, 9'h15A)
    // single shot armed mid-frame: grabs the next frame only
    {i_grab_live, i_grab_once} = 2'b01;
    step(3);
    i_grab_once = 1'b0;
    for (int f = 0; f < 2; f++) begin
      i_vvlp_board_model.show(8'h00, 4'h0, 8'h3C, 1'b1);
      step(3);
      i_vvlp_board_model.show(8'h00, 4'h0, 8'h3C, 1'b0);
      step(8);
      `CHK({o_grab_valid, o_grab_data}, {f == 0, 8'h3C})
    end
    $display("test grab done");
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    #1 i_rst = 0;
    t_regs();
    t_lut();
    t_vec();
    t_grab();
    complete_run();
  end
endmodule // testbench
